/* File: rtl/dgt_ddc_gain_and_test_pattern.v */
// Overview of operation
// [R1] second down-converter gain bit set doubles its output, else passes unscaled
// [R2] second down-converter doubling is never applied to the wideband filter path
// [R3] wideband gain bit doubles only the wideband filter path output
// [R4] software sets latency field per complex decimation ratio
// [R5] custom words one and two each built from low and high byte registers
// [R6] select 0 normal data, 1 all zeros, 2 all ones
// [R7] select 3 alternates the two toggle words each sample
// [R8] select 4 ramp steps one per clock from 0 to 16384
// [R9] select 6 repeats custom word one
// [R10] select 7 alternates custom word one and two
// [R11] select 8 outputs deskew word FFFFh
// [R12] common option clear: every stream uses the channel pattern select
// [R13] unused bits written zero; undefined select codes give normal data
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "dgt_defs.vh"

module dgt_ddc_gain_and_test_pattern (
    input wire clk,
    input wire sys_rst,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire wideband_path_sel,
    input wire [15:0] second_down_converter_i,
    input wire [15:0] second_down_converter_q,
    input wire [15:0] wideband_i,
    input wire [15:0] wideband_q,
    output wire [15:0] stream_i,
    output wire [15:0] stream_q,
    output wire [2:0] latency_align_setting
);

////////////////////////////////////////////////////////////////////////////////
// register file

reg second_converter_double_gain_reg;
reg wideband_double_gain_reg;
reg [2:0] latency_reg;
reg [7:0] cw1_low_reg;
reg [7:0] cw1_high_reg;
reg [7:0] cw2_low_reg;
reg [7:0] cw2_high_reg;
reg [3:0] pat_sel_reg;
reg common_opt_reg;
reg [7:0] rdata_next;

wire [15:0] custom_word_one;
wire [15:0] custom_word_two;

assign custom_word_one = {cw1_high_reg, cw1_low_reg}; // [R5]
assign custom_word_two = {cw2_high_reg, cw2_low_reg}; // [R5]
assign latency_align_setting = latency_reg; // [R4]

function addr_hit;
    input [9:0] addr;
    input [9:0] offset;
    begin
        addr_hit = (addr == offset);
    end
endfunction

// one write strobe per register; unmapped offsets raise none
reg wr_second_gain;
reg wr_latency;
reg wr_wide_gain;
reg wr_cw1_low;
reg wr_cw1_high;
reg wr_cw2_low;
reg wr_cw2_high;
reg wr_pat_sel;
reg wr_common_opt;

always @*
begin
    wr_second_gain = 1'b0;
    wr_latency = 1'b0;
    wr_wide_gain = 1'b0;
    wr_cw1_low = 1'b0;
    wr_cw1_high = 1'b0;
    wr_cw2_low = 1'b0;
    wr_cw2_high = 1'b0;
    wr_pat_sel = 1'b0;
    wr_common_opt = 1'b0;
    if (reg_wr)
    begin
        if (addr_hit(reg_addr, `DGT_OFF_SECOND_GAIN))
        begin
            wr_second_gain = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_LATENCY))
        begin
            wr_latency = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_WIDE_GAIN))
        begin
            wr_wide_gain = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_CW1_LOW))
        begin
            wr_cw1_low = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_CW1_HIGH))
        begin
            wr_cw1_high = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_CW2_LOW))
        begin
            wr_cw2_low = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_CW2_HIGH))
        begin
            wr_cw2_high = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_PAT_SEL))
        begin
            wr_pat_sel = 1'b1;
        end
        else if (addr_hit(reg_addr, `DGT_OFF_COMMON_OPT))
        begin
            wr_common_opt = 1'b1;
        end
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        second_converter_double_gain_reg <= `DGT_RST_BIT;
    end
    else if (wr_second_gain)
    begin
        second_converter_double_gain_reg <= reg_wdata[`DGT_GAIN_BIT]; // [R1]
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        latency_reg <= `DGT_RST_LAT;
    end
    else if (wr_latency)
    begin
        latency_reg <= reg_wdata[`DGT_LAT_HI:`DGT_LAT_LO]; // [R4]
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        wideband_double_gain_reg <= `DGT_RST_BIT;
    end
    else if (wr_wide_gain)
    begin
        wideband_double_gain_reg <= reg_wdata[`DGT_GAIN_BIT]; // [R3]
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pat_sel_reg <= `DGT_RST_SEL;
    end
    else if (wr_pat_sel)
    begin
        pat_sel_reg <= reg_wdata[`DGT_SEL_HI:`DGT_SEL_LO]; // [R12]
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        common_opt_reg <= `DGT_RST_BIT;
    end
    else if (wr_common_opt)
    begin
        common_opt_reg <= reg_wdata[`DGT_COMMON_BIT];
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        cw1_low_reg <= `DGT_RST_BYTE;
        cw1_high_reg <= `DGT_RST_BYTE;
        cw2_low_reg <= `DGT_RST_BYTE;
        cw2_high_reg <= `DGT_RST_BYTE;
    end
    else
    begin
        if (wr_cw1_low)
        begin
            cw1_low_reg <= reg_wdata; // [R5]
        end
        if (wr_cw1_high)
        begin
            cw1_high_reg <= reg_wdata; // [R5]
        end
        if (wr_cw2_low)
        begin
            cw2_low_reg <= reg_wdata; // [R5]
        end
        if (wr_cw2_high)
        begin
            cw2_high_reg <= reg_wdata; // [R5]
        end
    end
end

// unmapped offsets and reserved bits read zero
always @*
begin
    rdata_next = `DGT_RST_BYTE;
    if (addr_hit(reg_addr, `DGT_OFF_SECOND_GAIN))
    begin
        rdata_next[`DGT_GAIN_BIT] = second_converter_double_gain_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_LATENCY))
    begin
        rdata_next[`DGT_LAT_HI:`DGT_LAT_LO] = latency_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_WIDE_GAIN))
    begin
        rdata_next[`DGT_GAIN_BIT] = wideband_double_gain_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_CW1_LOW))
    begin
        rdata_next = cw1_low_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_CW1_HIGH))
    begin
        rdata_next = cw1_high_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_CW2_LOW))
    begin
        rdata_next = cw2_low_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_CW2_HIGH))
    begin
        rdata_next = cw2_high_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_PAT_SEL))
    begin
        rdata_next[`DGT_SEL_HI:`DGT_SEL_LO] = pat_sel_reg;
    end
    else if (addr_hit(reg_addr, `DGT_OFF_COMMON_OPT))
    begin
        rdata_next[`DGT_COMMON_BIT] = common_opt_reg;
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        reg_rdata <= `DGT_RST_BYTE;
    end
    else if (reg_rd)
    begin
        reg_rdata <= rdata_next;
    end
    else
    begin
        reg_rdata <= `DGT_RST_BYTE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// gain stage

reg [15:0] gained_i_reg;
reg [15:0] gained_q_reg;
reg [15:0] gained_i_next;
reg [15:0] gained_q_next;

// doubling keeps the low 16 bits; an overdriven input wraps
always @*
begin
    if (wideband_path_sel)
    begin
        // second converter gain ignored on the wideband path
        if (wideband_double_gain_reg) // [R2] [R3]
        begin
            gained_i_next = {wideband_i[14:0], 1'b0}; // [R3]
            gained_q_next = {wideband_q[14:0], 1'b0}; // [R3]
        end
        else
        begin
            gained_i_next = wideband_i;
            gained_q_next = wideband_q;
        end
    end
    else if (second_converter_double_gain_reg) // [R1]
    begin
        gained_i_next = {second_down_converter_i[14:0], 1'b0}; // [R1]
        gained_q_next = {second_down_converter_q[14:0], 1'b0}; // [R1]
    end
    else
    begin
        gained_i_next = second_down_converter_i;
        gained_q_next = second_down_converter_q;
    end
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        gained_i_reg <= `DGT_RST_WORD;
        gained_q_reg <= `DGT_RST_WORD;
    end
    else
    begin
        gained_i_reg <= gained_i_next;
        gained_q_reg <= gained_q_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// test pattern per stream, all from the channel select

wire [15:0] gained_stream [0:1];
wire [15:0] out_stream [0:1];

assign gained_stream[0] = gained_i_reg;
assign gained_stream[1] = gained_q_reg;

genvar s;
generate
    for (s = 0; s < 2; s = s + 1)
    begin : g_stream
        dgt_pattern_gen u_pat (
            .clk(clk),
            .sys_rst(sys_rst),
            .pat_sel(pat_sel_reg), // [R12]
            .custom_word_one(custom_word_one),
            .custom_word_two(custom_word_two),
            .sample_in(gained_stream[s]),
            .sample_out(out_stream[s])
        );
    end
endgenerate

assign stream_i = out_stream[0];
assign stream_q = out_stream[1];

endmodule

/* File: common/dgt_defs.vh */
`ifndef DGT_DEFS_VH
`define DGT_DEFS_VH

// register offsets (byte addresses on the 10-bit register port)
`define DGT_ADDR_W 10
`define DGT_OFF_SECOND_GAIN 10'h016
`define DGT_OFF_LATENCY 10'h01E
`define DGT_OFF_WIDE_GAIN 10'h01F
`define DGT_OFF_CW1_LOW 10'h033
`define DGT_OFF_CW1_HIGH 10'h034
`define DGT_OFF_CW2_LOW 10'h035
`define DGT_OFF_CW2_HIGH 10'h036
`define DGT_OFF_PAT_SEL 10'h037
`define DGT_OFF_COMMON_OPT 10'h039

// field layouts
`define DGT_GAIN_BIT 0
`define DGT_LAT_HI 6
`define DGT_LAT_LO 4
`define DGT_SEL_HI 3
`define DGT_SEL_LO 0
`define DGT_COMMON_BIT 0

// reset values
`define DGT_RST_BYTE 8'h00
`define DGT_RST_WORD 16'h0000
`define DGT_RST_LAT 3'h0
`define DGT_RST_SEL 4'h0
`define DGT_RST_BIT 1'h0

// pattern select codes
`define DGT_PAT_NORMAL 4'h0
`define DGT_PAT_ZEROS 4'h1
`define DGT_PAT_ONES 4'h2
`define DGT_PAT_TOGGLE 4'h3
`define DGT_PAT_RAMP 4'h4
`define DGT_PAT_SINGLE 4'h6
`define DGT_PAT_DOUBLE 4'h7
`define DGT_PAT_DESKEW 4'h8

// pattern words
`define DGT_WORD_ZEROS 16'h0000
`define DGT_WORD_ONES 16'hFFFF
`define DGT_WORD_TOGGLE_A 16'h2AAA
`define DGT_WORD_TOGGLE_B 16'h1555
`define DGT_WORD_DESKEW 16'hFFFF
`define DGT_RAMP_LAST 16'h4000
`define DGT_RAMP_STEP 16'h0001

`endif

/* File: rtl/dgt_pattern_gen.v */
`timescale 1ns/10ps
`include "dgt_defs.vh"

module dgt_pattern_gen (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] pat_sel,
    input wire [15:0] custom_word_one,
    input wire [15:0] custom_word_two,
    input wire [15:0] sample_in,
    output reg [15:0] sample_out
);

reg phase_reg;
reg [15:0] ramp_reg;
reg [15:0] ramp_next;
reg [15:0] out_next;

always @*
begin
    if (ramp_reg == `DGT_RAMP_LAST)
    begin
        ramp_next = `DGT_RST_WORD;
    end
    else
    begin
        ramp_next = ramp_reg + `DGT_RAMP_STEP; // [R8]
    end
end

always @*
begin
    case (pat_sel)
        `DGT_PAT_ZEROS: out_next = `DGT_WORD_ZEROS; // [R6]
        `DGT_PAT_ONES: out_next = `DGT_WORD_ONES; // [R6]
        `DGT_PAT_TOGGLE: out_next = phase_reg ? `DGT_WORD_TOGGLE_B : `DGT_WORD_TOGGLE_A; // [R7]
        `DGT_PAT_RAMP: out_next = ramp_reg; // [R8]
        `DGT_PAT_SINGLE: out_next = custom_word_one; // [R9]
        `DGT_PAT_DOUBLE: out_next = phase_reg ? custom_word_two : custom_word_one; // [R10]
        `DGT_PAT_DESKEW: out_next = `DGT_WORD_DESKEW; // [R11]
        default: out_next = sample_in; // [R6] [R13]
    endcase
end

always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        phase_reg <= `DGT_RST_BIT;
        ramp_reg <= `DGT_RST_WORD;
        sample_out <= `DGT_RST_WORD;
    end
    else
    begin
        phase_reg <= ~phase_reg;
        ramp_reg <= ramp_next;
        sample_out <= out_next;
    end
end

endmodule

/* File: sim/dgt_link_sink.sv */
`timescale 1ns/10ps
module dgt_link_sink (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] stream_i,
    output reg [15:0] prev_i
);
// keeps the previous lane sample for alternation checks
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        prev_i <= 16'h0000;
    else
        prev_i <= stream_i;
end
endmodule

/* File: sim/dgt_ddc_monitor.sv */
`timescale 1ns/10ps
`include "dgt_defs.vh"
module dgt_ddc_monitor (
    input wire clk,
    input wire sys_rst,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire wideband_path_sel,
    input wire [15:0] second_down_converter_i,
    input wire [15:0] wideband_i,
    input wire [15:0] stream_i,
    input wire [2:0] latency_align_setting
);
reg [3:0] sel_reg;
reg g2_reg;
reg gw_reg;
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sel_reg <= 4'h0;
        g2_reg <= 1'b0;
        gw_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
        if (reg_addr == `DGT_OFF_PAT_SEL)
            sel_reg <= reg_wdata[3:0];
        if (reg_addr == `DGT_OFF_SECOND_GAIN)
            g2_reg <= reg_wdata[0];
        if (reg_addr == `DGT_OFF_WIDE_GAIN)
            gw_reg <= reg_wdata[0];
    end
end
////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk);
endclocking
default disable iff (sys_rst);
sequence s_held(logic [3:0] c);
    (sel_reg == c) [*2];
endsequence
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
a_latency_write: assert property (reg_wr && reg_addr == `DGT_OFF_LATENCY
    |=> latency_align_setting == $past(reg_wdata[6:4])) else $error("latency field");
a_zeros_out: assert property (sel_reg == `DGT_PAT_ZEROS |=> stream_i == 16'h0000)
    else $error("zeros pattern");
a_deskew_out: assert property (sel_reg == `DGT_PAT_DESKEW |=> stream_i == 16'hFFFF)
    else $error("deskew pattern");
a_toggle_alt: assert property (s_held(`DGT_PAT_TOGGLE) |=> stream_i != $past(stream_i)
    && (stream_i == 16'h2AAA || stream_i == 16'h1555)) else $error("toggle pattern");
a_ramp_step: assert property (s_held(`DGT_PAT_RAMP) |=> stream_i ==
    (($past(stream_i) == 16'h4000) ? 16'h0000 : $past(stream_i) + 16'h0001))
    else $error("ramp step");
a_second_gain: assert property (!wideband_path_sel ##1 sel_reg == 4'h0
    |=> stream_i == ($past(second_down_converter_i, 2) << $past(g2_reg, 2)))
    else $error("second path gain");
a_wide_gain: assert property (wideband_path_sel ##1 sel_reg == 4'h0
    |=> stream_i == ($past(wideband_i, 2) << $past(gw_reg, 2)))
    else $error("wide path gain");
endmodule
bind dgt_ddc_gain_and_test_pattern dgt_ddc_monitor mon_u (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wideband_path_sel, .second_down_converter_i,
    .wideband_i, .stream_i, .latency_align_setting);

/* File: sim/test_dgt_ddc_gain_and_test_pattern.sv */
`timescale 1ns/10ps
module test_dgt_ddc_gain_and_test_pattern;
localparam [79:0] OFFS = {10'h037, 10'h036, 10'h035, 10'h034, 10'h033, 10'h01F, 10'h01E,
    10'h016};
localparam [31:0] LATS = {8'h50, 8'h40, 8'h20, 8'h10};
localparam [23:0] CODES = {4'h9, 4'h5, 4'h8, 4'h6, 4'h2, 4'h1};
localparam [95:0] EXPI = {16'h1234, 16'h1234, 16'hFFFF, 16'h9190, 16'hFFFF, 16'h0000};
localparam [95:0] EXPQ = {16'h0F0F, 16'h0F0F, 16'hFFFF, 16'h9190, 16'hFFFF, 16'h0000};
reg clk = 1'b0;
reg sys_rst = 1'b1;
reg [9:0] reg_addr = 10'h000;
reg [7:0] reg_wdata = 8'h00;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg wb_sel = 1'b0;
reg [15:0] sdc_i = 16'h1234;
wire [7:0] reg_rdata;
wire [15:0] stream_i, stream_q, prev_i;
wire [2:0] lat;
integer failures = 0;
integer num_checks = 0;
integer k;
reg [7:0] d;
initial forever #10 clk = ~clk;
dgt_ddc_gain_and_test_pattern dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wideband_path_sel(wb_sel), .second_down_converter_i(sdc_i),
    .second_down_converter_q(16'h0F0F), .wideband_i(16'h2345), .wideband_q(16'h0101),
    .stream_i(stream_i), .stream_q(stream_q), .latency_align_setting(lat));
dgt_link_sink sink_u (.clk(clk), .sys_rst(sys_rst), .stream_i(stream_i), .prev_i(prev_i));
////////////////////////////////////////////////////////////////
task chk(input string n, input [15:0] seen, input [15:0] exp);
begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
        failures = failures + 1;
        $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
end
endtask
task wr(input [9:0] a, input [7:0] v);
begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
end
endtask
task rd(input [9:0] a);
begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
end
endtask
task out(input string n, input [15:0] ei, input [15:0] eq);
begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(n, stream_i, ei);
    chk(n, stream_q, eq);
end
endtask
task alt(input [15:0] a, input [15:0] b);
begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("alternate", stream_i, (prev_i === a) ? b : a);
    chk("alternate prev", prev_i, (stream_i === a) ? b : a);
end
endtask
task end_of_test;
begin
    if (failures == 0 && num_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
////////////////////////////////////////////////////////////////
initial
begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 8; k = k + 1)
    begin
        rd(OFFS[k*10 +: 10]);
        chk("reset value", {8'h00, d}, 16'h0000);
    end
    rd(10'h039);
    chk("common option", {8'h00, d}, 16'h0000);
    for (k = 3; k < 7; k = k + 1)
    begin
        wr(OFFS[k*10 +: 10], {4'h9, k[3:0] - 4'h3});
        rd(OFFS[k*10 +: 10]);
        chk("custom byte", {8'h00, d}, {12'h009, k[3:0] - 4'h3});
    end
    for (k = 0; k < 4; k = k + 1)
    begin
        wr(10'h01E, LATS[k*8 +: 8]);
        @(negedge clk);
        chk("latency", {13'h0000, lat}, {13'h0000, LATS[k*8+4 +: 3]});
        rd(10'h01E);
        chk("latency byte", {8'h00, d}, {8'h00, LATS[k*8 +: 8]});
    end
    wr(10'h100, 8'hFF);
    rd(10'h100);
    chk("unmapped", {8'h00, d}, 16'h0000);
    out("plain", 16'h1234, 16'h0F0F);
    wr(10'h016, 8'h01);
    out("second gain", 16'h2468, 16'h1E1E);
    @(posedge clk);
    wb_sel <= 1'b1;
    out("wide no gain", 16'h2345, 16'h0101);
    wr(10'h01F, 8'h01);
    out("wide gain", 16'h468A, 16'h0202);
    @(posedge clk);
    wb_sel <= 1'b0;
    wr(10'h016, 8'h00);
    out("second only", 16'h1234, 16'h0F0F);
    for (k = 0; k < 6; k = k + 1)
    begin
        wr(10'h037, {4'h0, CODES[k*4 +: 4]});
        out("pattern", EXPI[k*16 +: 16], EXPQ[k*16 +: 16]);
    end
    // new input sample reaches the stream two edges later
    @(posedge clk);
    sdc_i <= 16'h0ABC;
    @(negedge clk);
    @(negedge clk);
    chk("pipeline old", stream_i, 16'h1234);
    @(negedge clk);
    chk("pipeline new", stream_i, 16'h0ABC);
    wr(10'h037, 8'h03);
    alt(16'h2AAA, 16'h1555);
    wr(10'h037, 8'h07);
    alt(16'h9190, 16'h9392);
    wr(10'h037, 8'h04);
    k = 0;
    @(negedge clk);
    while (stream_i !== 16'h4000 && k < 17000)
    begin
        @(negedge clk);
        k = k + 1;
    end
    if (k == 17000)
    begin
        failures = failures + 1;
    end
    else
    begin
        @(negedge clk);
        chk("ramp wrap", stream_i, 16'h0000);
        @(negedge clk);
        chk("ramp step", stream_i, 16'h0001);
    end
    end_of_test;
end
endmodule
